// ---- include/ccf_pkg.sv ----
// Constants, command kinds and the frame checksum for the chain command codec.
// Assumes both ends run on one clock and move one byte per clock on the link.
package ccf_pkg;

  // ----------------------------------------------------------------
  // Initialisation byte layout
  // ----------------------------------------------------------------
  localparam int          INIT_FRAME_BIT = 7;
  localparam int          INIT_KIND_MSB  = 6;
  localparam int          INIT_KIND_LSB  = 4;
  localparam int          INIT_SIZE_MSB  = 2;
  localparam logic [2:0]  READ_SIZE      = 3'h0;
  localparam logic [7:0]  RSP_INIT_BASE  = 8'h00;
  localparam logic [7:0]  MAX_READ_M1    = 8'h7F;
  localparam int          MAX_WRITE      = 8;

  // ----------------------------------------------------------------
  // Checksum
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  typedef enum logic [2:0] {
    KIND_SINGLE_RD = 3'h0,
    KIND_SINGLE_WR = 3'h1,
    KIND_STACK_RD  = 3'h2,
    KIND_STACK_WR  = 3'h3,
    KIND_BCAST_RD  = 3'h4,
    KIND_BCAST_WR  = 3'h5,
    KIND_REVERSE_WR = 3'h6,
    KIND_UNUSED    = 3'h7
  } ccf_kind_e;

  // Bit-serial, LSB first; a whole frame plus its checksum leaves zero
  function automatic logic [15:0] ccf_crc_byte(input logic [15:0] crcIn,
                                               input logic [7:0]  dataIn);
    logic [15:0] acc;
    acc = crcIn ^ {8'h00, dataIn};
    for (int b = 0; b < 8; b++)
    begin
      acc = acc[0] ? ((acc >> 1) ^ CRC_POLY) : (acc >> 1);
    end
    return acc;
  endfunction

  function automatic logic ccf_is_read(input logic [2:0] kind);
    return (kind == KIND_SINGLE_RD) || (kind == KIND_STACK_RD) || (kind == KIND_BCAST_RD);
  endfunction

endpackage

// ---- include/ccf_link_if.sv ----
// Byte link between the host end and the device end.
// Assumes a common clock; each valid byte is taken on the edge it is high.
interface ccf_link_if;
  logic       cmdValid;
  logic [7:0] cmdByte;
  logic       rspValid;
  logic [7:0] rspByte;

  modport host   (output cmdValid, output cmdByte, input rspValid, input rspByte);
  modport device (input cmdValid, input cmdByte, output rspValid, output rspByte);
endinterface

// ---- hdl/ccf_device_end.sv ----
// Device end of the chain command codec: parses command frames, applies
// writes and sends read responses.
// Assumes register storage outside, read combinationally from regReadAddr,
// and a neighbour that pulses aboveFrameDone when the device above has sent.
//
// How it works
// RULE1 - Read command carries start address and count
// RULE2 - Read size field zero, at most 128
// RULE3 - Response length follows requested byte count
// RULE4 - Count byte is bytes minus one
// RULE5 - A write touches at most eight registers
// RULE6 - Write size field is bytes minus one
// RULE7 - Write bytes go to ascending addresses
// RULE8 - Unlock keys written in one command
// RULE9 - Single-device commands carry one address byte
// RULE10 - Stack and broadcast frames lack address byte
// RULE11 - Multi-byte broadcast write ends with checksum
// RULE12 - Stacked responses go highest address first
// RULE13 - Response: init, address, start, data, checksum
// RULE14 - Bad checksum means command is dropped
// RULE15 - Kind field selects write or read
// RULE16 - At most one response per command
// RULE17 - Diagnostic bit inverts response checksum
// RULE18 - Response data in ascending address order
module ccf_device_end
  import ccf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  ccf_link_if.device      link,
  input  wire logic [7:0] deviceAddress,
  input  wire logic       isBase,
  input  wire logic       isStackTop,
  input  wire logic       aboveFrameDone,
  input  wire logic       invertResponseCrc,
  input  wire logic [7:0] regReadData,
  output logic            regWrite,
  output logic [15:0]     regWriteAddr,
  output logic [7:0]      regWriteData,
  output logic [15:0]     regReadAddr,
  output logic            crcError,
  output logic            frameError
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RX_INIT, RX_DEV, RX_ADRH, RX_ADRL, RX_DATA, RX_CRCL, RX_CRCH,
    EXEC_WR, WAIT_ABOVE,
    TX_INIT, TX_DEV, TX_ADRH, TX_ADRL, TX_DATA, TX_CRCL, TX_CRCH
  } ccf_dev_state_e;

  ccf_dev_state_e state;
  logic [2:0]     kind;
  logic [2:0]     size;
  logic [7:0]     frameDev;
  logic [15:0]    startAddr;
  logic [7:0]     dataBuf [MAX_WRITE];
  logic [6:0]     idx;
  logic [15:0]    crc;
  logic           rspValid;
  logic [7:0]     rspByte;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire        byteIn      = link.cmdValid;
  wire [7:0]  inByte      = link.cmdByte;
  wire [15:0] crcNextRx   = ccf_crc_byte(crc, inByte);
  wire [2:0]  inKind      = inByte[INIT_KIND_MSB:INIT_KIND_LSB];
  wire        kindRead    = ccf_is_read(kind); // [RULE15]
  wire        isSingle    = (kind == KIND_SINGLE_RD) || (kind == KIND_SINGLE_WR); // [RULE9]
  wire        isStack     = (kind == KIND_STACK_RD) || (kind == KIND_STACK_WR);
  // Data bytes: a read carries one count byte, a write size+1 bytes
  wire [6:0]  lastIdx     = kindRead ? 7'h00 : {4'h0, size}; // [RULE6] [RULE5]
  wire [6:0]  readLast    = dataBuf[0][6:0]; // [RULE4]
  wire        readSizeBad = kindRead && ((size != READ_SIZE) || (dataBuf[0] > MAX_READ_M1)); // [RULE2]
  wire        addressed   = isSingle ? (frameDev == deviceAddress) : !(isStack && isBase);
  wire        crcGood     = (crcNextRx == CRC_GOOD);
  wire [15:0] crcNextTx   = ccf_crc_byte(crc, rspByte);
  wire [7:0]  crcOut      = crcNextTx[7:0] ^ {8{invertResponseCrc}}; // [RULE17]
  // Stack and broadcast reads wait for the device above unless this one is the top
  wire        mustWait    = (kind != KIND_SINGLE_RD) && !isStackTop; // [RULE12]

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state        <= RX_INIT;
      kind         <= KIND_SINGLE_RD;
      size         <= 3'h0;
      frameDev     <= 8'h00;
      startAddr    <= 16'h0000;
      idx          <= 7'h00;
      crc          <= CRC_INIT;
      rspValid     <= 1'b0;
      rspByte      <= 8'h00;
      regWrite     <= 1'b0;
      regWriteAddr <= 16'h0000;
      regWriteData <= 8'h00;
      regReadAddr  <= 16'h0000;
      crcError     <= 1'b0;
      frameError   <= 1'b0;
      for (int i = 0; i < MAX_WRITE; i++)
      begin
        dataBuf[i] <= 8'h00;
      end
    end
    else
    begin
      regWrite   <= 1'b0;
      crcError   <= 1'b0;
      frameError <= 1'b0;
      rspValid   <= 1'b0;
      unique case (state)
        RX_INIT:
          if (byteIn)
          begin
            if (!inByte[INIT_FRAME_BIT] || inKind == KIND_UNUSED)
            begin
              frameError <= 1'b1;
            end
            else
            begin
              kind  <= inKind;
              size  <= inByte[INIT_SIZE_MSB:0];
              idx   <= 7'h00;
              crc   <= ccf_crc_byte(CRC_INIT, inByte);
              state <= (inKind == KIND_SINGLE_RD || inKind == KIND_SINGLE_WR)
                       ? RX_DEV : RX_ADRH; // [RULE9] [RULE10]
            end
          end
        RX_DEV:
          if (byteIn)
          begin
            frameDev <= inByte;
            crc      <= crcNextRx;
            state    <= RX_ADRH;
          end
        RX_ADRH:
          if (byteIn)
          begin
            startAddr[15:8] <= inByte; // [RULE1]
            crc             <= crcNextRx;
            state           <= RX_ADRL;
          end
        RX_ADRL:
          if (byteIn)
          begin
            startAddr[7:0] <= inByte;
            crc            <= crcNextRx;
            state          <= RX_DATA;
          end
        RX_DATA:
          if (byteIn)
          begin
            dataBuf[idx[2:0]] <= inByte; // [RULE8]
            crc               <= crcNextRx;
            idx               <= idx + 7'h01;
            if (idx == lastIdx)
            begin
              state <= RX_CRCL; // [RULE11]
            end
          end
        RX_CRCL:
          if (byteIn)
          begin
            crc   <= crcNextRx;
            state <= RX_CRCH;
          end
        RX_CRCH:
          if (byteIn)
          begin
            idx <= 7'h00;
            if (!crcGood)
            begin
              crcError <= 1'b1; // [RULE14]
              state    <= RX_INIT;
            end
            else if (readSizeBad)
            begin
              frameError <= 1'b1; // [RULE2]
              state      <= RX_INIT;
            end
            else if (!addressed)
            begin
              state <= RX_INIT;
            end
            else if (!kindRead)
            begin
              state <= EXEC_WR; // [RULE15]
            end
            else
            begin
              state <= mustWait ? WAIT_ABOVE : TX_INIT; // [RULE12]
            end
          end
        EXEC_WR:
          begin
            regWrite     <= 1'b1;
            regWriteAddr <= startAddr + {9'h000, idx}; // [RULE7]
            regWriteData <= dataBuf[idx[2:0]];
            idx          <= idx + 7'h01;
            if (idx == lastIdx)
            begin
              state <= RX_INIT;
            end
          end
        WAIT_ABOVE:
          if (aboveFrameDone)
          begin
            state <= TX_INIT; // [RULE12]
          end
        TX_INIT:
          begin
            rspValid <= 1'b1;
            rspByte  <= RSP_INIT_BASE | {1'b0, readLast}; // [RULE13]
            crc      <= CRC_INIT;
            state    <= TX_DEV;
          end
        TX_DEV:
          begin
            rspValid <= 1'b1;
            rspByte  <= deviceAddress;
            crc      <= crcNextTx;
            state    <= TX_ADRH;
          end
        TX_ADRH:
          begin
            rspValid <= 1'b1;
            rspByte  <= startAddr[15:8];
            crc      <= crcNextTx;
            state    <= TX_ADRL;
          end
        TX_ADRL:
          begin
            rspValid    <= 1'b1;
            rspByte     <= startAddr[7:0];
            crc         <= crcNextTx;
            regReadAddr <= startAddr; // [RULE18]
            state       <= TX_DATA;
          end
        TX_DATA:
          begin
            rspValid    <= 1'b1;
            rspByte     <= regReadData; // [RULE3]
            crc         <= crcNextTx;
            regReadAddr <= regReadAddr + 16'h0001; // [RULE18]
            idx         <= idx + 7'h01;
            if (idx == readLast)
            begin
              state <= TX_CRCL;
            end
          end
        TX_CRCL:
          begin
            rspValid <= 1'b1;
            rspByte  <= crcOut[7:0]; // [RULE17]
            crc      <= crcNextTx;
            state    <= TX_CRCH;
          end
        TX_CRCH:
          begin
            rspValid <= 1'b1;
            rspByte  <= crc[15:8] ^ {8{invertResponseCrc}}; // [RULE17]
            state    <= RX_INIT; // [RULE16]
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link drive
  // ----------------------------------------------------------------
  assign link.rspValid = rspValid;
  assign link.rspByte  = rspByte;

endmodule

// ---- hdl/ccf_host_end.sv ----
// Host end of the chain command codec: builds command frames from a request
// and parses response frames back into bytes.
// Assumes the user holds request fields stable while cmdStart is high.
module ccf_host_end
  import ccf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  ccf_link_if.host         link,
  input  wire logic        cmdStart,
  input  wire logic [2:0]  cmdKind,
  input  wire logic [6:0]  cmdCountM1,
  input  wire logic [7:0]  cmdDevAddr,
  input  wire logic [15:0] cmdRegAddr,
  input  wire logic [63:0] cmdData,
  output logic             busy,
  output logic             rxDataValid,
  output logic [7:0]       rxData,
  output logic [7:0]       rxDevAddr,
  output logic [15:0]      rxRegAddr,
  output logic             rxFrameDone,
  output logic             rxCrcOk
);

  // ----------------------------------------------------------------
  // Command builder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE, TX_DEV, TX_ADRH, TX_ADRL, TX_DATA, TX_CRCL, TX_CRCH
  } ccf_htx_state_e;

  ccf_htx_state_e txState;
  logic [2:0]     kind;
  logic [6:0]     countM1;
  logic [7:0]     devAddr;
  logic [15:0]    regAddr;
  logic [63:0]    dataHold;
  logic [2:0]     txIdx;
  logic [15:0]    txCrc;
  logic           cmdValid;
  logic [7:0]     cmdByte;

  wire        isRead   = ccf_is_read(cmdKind);
  wire        isSingle = (cmdKind == KIND_SINGLE_RD) || (cmdKind == KIND_SINGLE_WR);
  // Reads send size zero and one count byte; writes send bytes minus one
  wire [2:0]  sizeFld  = isRead ? READ_SIZE : cmdCountM1[2:0];
  wire [7:0]  initByte = {1'b1, cmdKind, 1'b0, sizeFld};
  wire        lastData = ccf_is_read(kind) ? 1'b1 : (txIdx == countM1[2:0]);
  wire [7:0]  readCnt  = {1'b0, countM1};
  wire [7:0]  dataByte = ccf_is_read(kind) ? readCnt : dataHold[8*txIdx +: 8];
  wire [7:0]  nextByte = (txState == TX_IDLE) ? initByte :
                         (txState == TX_DEV)  ? devAddr :
                         (txState == TX_ADRH) ? regAddr[15:8] :
                         (txState == TX_ADRL) ? regAddr[7:0] :
                         (txState == TX_DATA) ? dataByte :
                         (txState == TX_CRCL) ? txCrc[7:0] : txCrc[15:8];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txState  <= TX_IDLE;
      kind     <= KIND_SINGLE_RD;
      countM1  <= 7'h00;
      devAddr  <= 8'h00;
      regAddr  <= 16'h0000;
      dataHold <= 64'h0;
      txIdx    <= 3'h0;
      txCrc    <= CRC_INIT;
      cmdValid <= 1'b0;
      cmdByte  <= 8'h00;
      busy     <= 1'b0;
    end
    else
    begin
      cmdValid <= 1'b0;
      unique case (txState)
        TX_IDLE:
          if (cmdStart)
          begin
            kind     <= cmdKind;
            countM1  <= cmdCountM1; // [RULE4]
            devAddr  <= cmdDevAddr;
            regAddr  <= cmdRegAddr; // [RULE1]
            dataHold <= cmdData; // [RULE8]
            txIdx    <= 3'h0;
            busy     <= 1'b1;
            cmdValid <= 1'b1;
            cmdByte  <= initByte; // [RULE2] [RULE6] [RULE5]
            txCrc    <= ccf_crc_byte(CRC_INIT, initByte);
            txState  <= isSingle ? TX_DEV : TX_ADRH; // [RULE9] [RULE10]
          end
        TX_DEV, TX_ADRH, TX_ADRL, TX_DATA:
          begin
            cmdValid <= 1'b1;
            cmdByte  <= nextByte;
            txCrc    <= ccf_crc_byte(txCrc, nextByte);
            if (txState == TX_DATA)
            begin
              txIdx <= txIdx + 3'h1;
            end
            if (txState == TX_DEV)
            begin
              txState <= TX_ADRH;
            end
            else if (txState == TX_ADRH)
            begin
              txState <= TX_ADRL;
            end
            else if (txState == TX_ADRL)
            begin
              txState <= TX_DATA;
            end
            else if (lastData)
            begin
              txState <= TX_CRCL; // [RULE11]
            end
          end
        TX_CRCL:
          begin
            cmdValid <= 1'b1;
            cmdByte  <= nextByte;
            txState  <= TX_CRCH;
          end
        TX_CRCH:
          begin
            cmdValid <= 1'b1;
            cmdByte  <= nextByte;
            busy     <= 1'b0;
            txState  <= TX_IDLE;
          end
      endcase
    end
  end

  assign link.cmdValid = cmdValid;
  assign link.cmdByte  = cmdByte;

  // ----------------------------------------------------------------
  // Response parser
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_INIT, RX_DEV, RX_ADRH, RX_ADRL, RX_DATA, RX_CRCL, RX_CRCH
  } ccf_hrx_state_e;

  ccf_hrx_state_e rxState;
  logic [6:0]     rxLast;
  logic [6:0]     rxIdx;
  logic [15:0]    rxCrc;

  wire        rxIn   = link.rspValid;
  wire [7:0]  rxByte = link.rspByte;
  wire [15:0] rxNext = ccf_crc_byte(rxCrc, rxByte);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxState     <= RX_INIT;
      rxLast      <= 7'h00;
      rxIdx       <= 7'h00;
      rxCrc       <= CRC_INIT;
      rxDataValid <= 1'b0;
      rxData      <= 8'h00;
      rxDevAddr   <= 8'h00;
      rxRegAddr   <= 16'h0000;
      rxFrameDone <= 1'b0;
      rxCrcOk     <= 1'b0;
    end
    else
    begin
      rxDataValid <= 1'b0;
      rxFrameDone <= 1'b0;
      if (rxIn)
      begin
        rxCrc <= (rxState == RX_INIT) ? ccf_crc_byte(CRC_INIT, rxByte) : rxNext;
        unique case (rxState)
          RX_INIT:
            begin
              rxLast  <= rxByte[6:0];
              rxIdx   <= 7'h00;
              rxState <= RX_DEV;
            end
          RX_DEV:
            begin
              rxDevAddr <= rxByte;
              rxState   <= RX_ADRH;
            end
          RX_ADRH:
            begin
              rxRegAddr[15:8] <= rxByte;
              rxState         <= RX_ADRL;
            end
          RX_ADRL:
            begin
              rxRegAddr[7:0] <= rxByte;
              rxState        <= RX_DATA;
            end
          RX_DATA:
            begin
              rxDataValid <= 1'b1;
              rxData      <= rxByte;
              rxIdx       <= rxIdx + 7'h01;
              if (rxIdx == rxLast)
              begin
                rxState <= RX_CRCL;
              end
            end
          RX_CRCL:
            rxState <= RX_CRCH;
          RX_CRCH:
            begin
              rxFrameDone <= 1'b1;
              rxCrcOk     <= (rxNext == CRC_GOOD);
              rxState     <= RX_INIT;
            end
        endcase
      end
    end
  end

endmodule

// ---- bench/ccf_link_properties.sv ----
// Checker on the command and response byte streams of the codec link.
// Assumes one clock and one byte per valid cycle on each direction.
module ccf_link_properties
  import ccf_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       cmdValid,
  input wire logic [7:0] cmdByte,
  input wire logic       rspValid,
  input wire logic [7:0] rspByte
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Frame trackers
  // ----------------------------------------------------------------
  logic [7:0]  cmdLeft;
  logic [7:0]  rspLeft;
  logic [7:0]  cmdCnt;
  logic [15:0] cmdCrc;
  logic [2:0]  cmdKind;
  logic        rspSeen;

  // Own checksum step, kept apart so a shared slip cannot hide
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction

  wire         cmdFirst = cmdValid && (cmdLeft == 8'h00);
  wire         cmdLast  = cmdValid && (cmdLeft == 8'h01);
  wire         rspFirst = rspValid && (rspLeft == 8'h00);
  wire  [2:0]  kindIn   = cmdByte[6:4];
  wire         readIn   = (kindIn == 3'h0) || (kindIn == 3'h2) || (kindIn == 3'h4);
  wire         readKept = (cmdKind == 3'h0) || (cmdKind == 3'h2) || (cmdKind == 3'h4);
  wire  [7:0]  cmdLen   = 8'h05 + {7'h00, kindIn < 3'h2} + (readIn ? 8'h00 : {5'h00, cmdByte[2:0]});
  wire  [15:0] crcNext  = crc_step(cmdFirst ? CRC_INIT : cmdCrc, cmdByte);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmdLeft <= 8'h00;
      rspLeft <= 8'h00;
      cmdCnt  <= 8'h00;
      cmdCrc  <= 16'h0000;
      cmdKind <= 3'h0;
      rspSeen <= 1'b0;
    end
    else
    begin
      cmdLeft <= cmdFirst ? cmdLen : (cmdValid ? cmdLeft - 8'h01 : cmdLeft);
      rspLeft <= rspFirst ? 8'h06 + {1'b0, rspByte[6:0]} : (rspValid ? rspLeft - 8'h01 : rspLeft);
      cmdCnt  <= (cmdValid && cmdLeft == 8'h03) ? cmdByte : cmdCnt;
      cmdCrc  <= cmdValid ? crcNext : cmdCrc;
      cmdKind <= cmdFirst ? kindIn : cmdKind;
      rspSeen <= cmdLast ? 1'b0 : (rspFirst ? 1'b1 : rspSeen);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_cmd_init_flag: assert property (cmdFirst |-> cmdByte[7])
    else $error("command frame starts without frame flag");
  a_read_size_zero: assert property (cmdFirst && readIn |-> cmdByte[3:0] == 4'h0)
    else $error("read init byte carries a size");
  a_write_size_max: assert property (cmdFirst && !readIn |-> !cmdByte[3])
    else $error("write size beyond eight bytes");
  a_cmd_no_gap: assert property (cmdValid && cmdLeft > 8'h01 |=> cmdValid)
    else $error("gap inside command frame");
  a_cmd_crc_good: assert property (cmdLast |-> crcNext == CRC_GOOD)
    else $error("command checksum wrong");
  a_rsp_no_gap: assert property (rspValid && rspLeft > 8'h01 |=> rspValid)
    else $error("gap inside response frame");
  a_rsp_after_read: assert property (rspFirst |-> $past(cmdLast, 2) && readKept)
    else $error("response not right after a read command");
  a_rsp_count_echo: assert property (rspFirst |-> rspByte == {1'b0, cmdCnt[6:0]})
    else $error("response length differs from requested count");
  a_one_rsp: assert property (rspFirst |-> !rspSeen)
    else $error("second response to one command");
endmodule

// ---- bench/chain_command_frame_codec_tb.sv ----
// Bench joining host end and device end over one link.
// Assumes register contents modelled as a fixed function of address.
module chain_command_frame_codec_tb
  import ccf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV  = 8'h05;
  localparam logic [7:0] SALT = 8'h3C;
  logic        clk, reset_n, cmdStart, invCrc, regWrite, busy, rxDataValid;
  logic        rxFrameDone, rxCrcOk, crcError, frameError;
  logic [2:0]  cmdKind;
  logic [6:0]  cmdCountM1;
  logic [7:0]  cmdDevAddr, regWriteData, rxData, rxDevAddr;
  logic [15:0] cmdRegAddr, regWriteAddr, regReadAddr, rxRegAddr;
  logic [63:0] cmdData;
  logic [31:0] seed;
  int          bad_count, tests_run;
  logic [23:0] wrQ[$];
  logic [7:0]  rdQ[$];
  logic [24:0] frQ[$];
  wire  [7:0]  regReadData = regReadAddr[7:0] + SALT;

  ccf_link_if link();
  ccf_host_end ccf_host_end_inst (.clk(clk), .reset_n(reset_n), .link(link),
    .cmdStart(cmdStart), .cmdKind(cmdKind), .cmdCountM1(cmdCountM1), .cmdDevAddr(cmdDevAddr),
    .cmdRegAddr(cmdRegAddr), .cmdData(cmdData), .busy(busy), .rxDataValid(rxDataValid),
    .rxData(rxData), .rxDevAddr(rxDevAddr), .rxRegAddr(rxRegAddr),
    .rxFrameDone(rxFrameDone), .rxCrcOk(rxCrcOk));
  // Lone stack top: no neighbour above to wait for
  ccf_device_end ccf_device_end_inst (.clk(clk), .reset_n(reset_n), .link(link),
    .deviceAddress(DEV), .isBase(1'b0), .isStackTop(1'b1), .aboveFrameDone(1'b0),
    .invertResponseCrc(invCrc), .regReadData(regReadData), .regWrite(regWrite),
    .regWriteAddr(regWriteAddr), .regWriteData(regWriteData), .regReadAddr(regReadAddr),
    .crcError(crcError), .frameError(frameError));
  ccf_link_properties ccf_link_properties_inst (.clk(clk), .reset_n(reset_n),
    .cmdValid(link.cmdValid), .cmdByte(link.cmdByte), .rspValid(link.rspValid),
    .rspByte(link.rspByte));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic fail(input string msg);
    $display("ERROR t=%0t %s", $time, msg);
    bad_count++;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
  endtask

  task automatic cmp_write(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("write %h expected %h", got, exp));
  endtask

  task automatic cmp_frame(input logic [24:0] got, input logic [24:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("header %h expected %h", got, exp));
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Device must finish one frame before the next
  task automatic wait_idle();
    int n = 0;
    while ((busy !== 1'b0 || wrQ.size() || rdQ.size() || frQ.size()) && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 2000)
    begin
      fail("timeout");
      complete_run();
    end
    else
    begin
      repeat (4) @(posedge clk);
      #1;
    end
  endtask

  task automatic send(input logic [2:0] k, input logic [6:0] c, input logic [7:0] d,
                      input logic [15:0] a, input logic [63:0] v);
    logic hit;
    hit = (k > KIND_SINGLE_WR) || (d == DEV);
    cmdKind = k;
    cmdCountM1 = c;
    cmdDevAddr = d;
    cmdRegAddr = a;
    cmdData = v;
    cmdStart = 1'b1;
    @(posedge clk);
    #1;
    cmdStart = 1'b0;
    if (hit && (k == KIND_SINGLE_RD || k == KIND_STACK_RD || k == KIND_BCAST_RD))
    begin
      for (int i = 0; i <= c; i++)
        rdQ.push_back(a[7:0] + 8'(i) + SALT);
      frQ.push_back({DEV, a, !invCrc});
    end
    else if (hit)
      for (int i = 0; i <= c[2:0]; i++)
        wrQ.push_back({a + 16'(i), v[8 * i +: 8]});
    wait_idle();
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset_n)
    begin
      if (regWrite && wrQ.size() == 0)
        fail("unexpected write");
      else if (regWrite)
        cmp_write({regWriteAddr, regWriteData}, wrQ.pop_front());
      if (rxDataValid && rdQ.size() == 0)
        fail("unexpected data");
      else if (rxDataValid)
        cmp_byte(rxData, rdQ.pop_front());
      if (rxFrameDone && frQ.size() == 0)
        fail("unexpected response");
      else if (rxFrameDone)
        cmp_frame({rxDevAddr, rxRegAddr, rxCrcOk}, frQ.pop_front());
      if (crcError || frameError)
        fail("frame dropped");
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'hBA1C;
    bad_count = 0;
    tests_run = 0;
    reset_n = 1'b0;
    cmdStart = 1'b0;
    invCrc = 1'b0;
    cmdKind = 3'h0;
    cmdCountM1 = 7'h00;
    cmdDevAddr = 8'h00;
    cmdRegAddr = 16'h0000;
    cmdData = 64'h0;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    for (int n = 0; n < MAX_WRITE; n++)
      send(KIND_SINGLE_WR, 7'(n), DEV, 16'(rnd()), {rnd(), rnd()});
    $display("single writes done");
    send(KIND_SINGLE_RD, 7'h0B, DEV, 16'h0215, 64'h0);
    send(KIND_SINGLE_RD, 7'h7F, DEV, 16'(rnd()), 64'h0);
    for (int n = 0; n < 4; n++)
      send(KIND_SINGLE_RD, 7'(rnd() & 32'h1F), DEV, 16'(rnd()), 64'h0);
    $display("single reads done");
    for (int k = 2; k < 7; k++)
      send(3'(k), 7'(rnd() & 32'h7), 8'h00, 16'(rnd()), {rnd(), rnd()});
    $display("stack and broadcast done");
    send(KIND_SINGLE_RD, 7'h03, DEV ^ 8'h01, 16'h0215, 64'h0);
    send(KIND_SINGLE_WR, 7'h03, DEV + 8'h01, 16'h0100, 64'h02B778BC);
    $display("unaddressed done");
    invCrc = 1'b1;
    send(KIND_SINGLE_RD, 7'h02, DEV, 16'h0100, 64'h0);
    invCrc = 1'b0;
    $display("inverted checksum done");
    complete_run();
  end
endmodule
